// ### src/twm_pkg.sv
// Constants and types for the two-wire master transmitter block
package twm_pkg;
  // Control register bit positions
  localparam int unsigned CTRL_FLAG = 7;
  localparam int unsigned CTRL_ACKEN = 6;
  localparam int unsigned CTRL_START = 5;
  localparam int unsigned CTRL_STOP = 4;
  localparam int unsigned CTRL_WCOL = 3;
  localparam int unsigned CTRL_EN = 2;
  localparam int unsigned CTRL_IE = 0;

  // Status codes, prescaler bits read as zero
  localparam logic [7:0] ST_START_SENT = 8'h08;
  localparam logic [7:0] ST_RSTART_SENT = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_MASK = 8'hF8;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hF8;
  localparam logic [7:0] DATA_RST = 8'hFF;

  // Bit timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BIT_TIME_NS = 10000;
  localparam int unsigned QTR_CYCLES = (BIT_TIME_NS / CLK_PERIOD_NS) / 4;
  localparam int unsigned BITS_PER_BYTE = 9;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_START, SEQ_BIT, SEQ_HOLD, SEQ_STOP, SEQ_RSTART
  } twm_seq_e;

  // Operating roles
  typedef enum logic [2:0] {
    ROLE_NONE, ROLE_MASTER_TX, ROLE_MASTER_RX, ROLE_SLAVE_TX, ROLE_SLAVE_RX
  } twm_role_e;
endpackage

// ### src/twm_sync.sv
// Two flip-flop synchroniser for bus line inputs
`timescale 1ns/100ps
`default_nettype none
module twm_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Lines
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // One two-stage chain per line, idle level high
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_line
      always_ff @(posedge clock) begin
        if (rst) begin
          meta_r[gi] <= 1'b1;
          sync_out[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= async_in[gi];
          sync_out[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate
endmodule // twm_sync
`default_nettype wire

// ### src/twm_master.sv
// Two-wire master transmitter sequencer with control, status and data registers
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] Role output covers master transmit and master receive only; the slave transmit and slave receive roles are never set.
// [R2] Direction bit after address: high means read, low means write.
// [R3] Acknowledge is low on data line, not-acknowledge is high.
// [R4] While flag is set the bus transfer is suspended.
// [R5] Software masks status with 0xF8 before comparing codes.
// [R6] Address write bit enters master transmit, read bit enters master receive.
// [R7] Software requests start by writing control pattern 1x10x10x.
// [R8] Writing one to the flag bit clears the flag.
// [R9] Bus sequencer works only while the enable bit is one; register writes and write collision still act while it is zero.
// [R10] Start is issued only once the bus is seen free.
// [R11] After start, flag is set with status 0x08.
// [R12] Software loads data then writes 1x00x10x to send a byte.
// [R13] After write address: 0x18 ack, 0x20 nack; lost arbitration drops to idle without setting the flag or 0x38.
// [R14] Data write while flag is low is dropped and sets write collision.
// [R15] Byte load and flag clear repeat until stop or repeated start.
// [R16] Software ends a transfer with control pattern 1x01x10x.
// [R17] After repeated start, flag is set with status 0x10.
// [R18] Repeated start keeps bus ownership and allows role change without stop.
// [R19] Clock line held low while flag is set.
// [R20] No flag is set after a stop.
// [R21] Stop request bit clears itself once stop is sent.
// [R22] Status is updated in the same cycle the flag is set.
// [R23] After a transmitted data byte: 0x28 on ack, 0x30 on nack.
module twm_master #(
  parameter int unsigned QTR = twm_pkg::QTR_CYCLES,
  parameter logic [7:0] RX_ADDR_ACK = 8'h40,
  parameter logic [7:0] RX_ADDR_NACK = 8'h48,
  parameter logic [7:0] RX_DATA_ACK = 8'h50,
  parameter logic [7:0] RX_DATA_NACK = 8'h58
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control register access
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] serial_control_reg,
  // Data register access
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] serial_data_reg,
  // Status
  output logic [7:0] serial_status_reg,
  output logic [2:0] role,
  // Bus clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Bus data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  logic flag_r, ackena_r, sta_r, sto_r, wc_r, en_r, ie_r;
  logic [7:0] data_r, status_r, shift_r;
  logic [1:0] lines_s;
  logic scl_s, sda_s, sda_d_r, busy_r;
  logic scl_oe_r, sda_oe_r, scl_out_r, sda_out_r;
  logic [15:0] cnt_r;
  logic [1:0] qtr_r;
  logic [3:0] bit_r;
  logic addr_phase_r, rx_r, ack_bit_r, repeat_r, lost_r;
  logic set_flag, tick, end_bit;
  logic [7:0] code_nxt;
  twm_pkg::twm_seq_e seq_r;
  twm_pkg::twm_role_e role_r;

  // Pin synchronisation
  twm_sync #(.WIDTH(2)) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in({scl_in, sda_in}),
    .sync_out(lines_s)
  );
  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  // Register and pin outputs
  assign serial_control_reg = {flag_r, ackena_r, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
  assign serial_data_reg = data_r;
  assign serial_status_reg = status_r;
  assign role = role_r; // [R1]
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign scl_out = scl_out_r;
  assign sda_out = sda_out_r;

  // Quarter-bit timing, high quarters wait for a stretched clock
  assign tick = (cnt_r == 16'(QTR - 1)) && !(qtr_r[1] && !scl_s);
  assign end_bit = (seq_r == twm_pkg::SEQ_BIT) && tick && (qtr_r == 2'd3);

  // Status code for the event that raises the flag
  always_comb begin
    set_flag = 1'b0;
    code_nxt = status_r;
    if (seq_r == twm_pkg::SEQ_START && tick && qtr_r == 2'd1) begin
      set_flag = 1'b1;
      code_nxt = repeat_r ? twm_pkg::ST_RSTART_SENT : twm_pkg::ST_START_SENT; // [R11] [R17]
    end else if (end_bit && lost_r) begin
      set_flag = 1'b1;
      code_nxt = twm_pkg::ST_ARB_LOST; // [R13]
    end else if (end_bit && bit_r == 4'(twm_pkg::BITS_PER_BYTE - 1)) begin
      set_flag = 1'b1;
      if (addr_phase_r && !data_r[0]) begin
        code_nxt = sda_s ? twm_pkg::ST_ADDR_NACK : twm_pkg::ST_ADDR_ACK; // [R13] [R3]
      end else if (addr_phase_r) begin
        code_nxt = sda_s ? RX_ADDR_NACK : RX_ADDR_ACK;
      end else if (!rx_r) begin
        code_nxt = sda_s ? twm_pkg::ST_DATA_NACK : twm_pkg::ST_DATA_ACK; // [R23]
      end else begin
        code_nxt = ackena_r ? RX_DATA_ACK : RX_DATA_NACK;
      end
    end
  end

  // Interrupt flag: hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (set_flag) begin
      flag_r <= 1'b1;
    end else if (ctrl_wr && ctrl_wdata[twm_pkg::CTRL_FLAG]) begin
      flag_r <= 1'b0; // [R8]
    end
  end

  // Status register follows the flag in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= twm_pkg::STATUS_RST;
    end else if (set_flag) begin
      status_r <= code_nxt & twm_pkg::ST_MASK; // [R22]
    end
  end

  // Control bits written by software
  always_ff @(posedge clock) begin
    if (rst) begin
      ackena_r <= twm_pkg::CTRL_RST[twm_pkg::CTRL_ACKEN];
      sta_r <= twm_pkg::CTRL_RST[twm_pkg::CTRL_START];
      en_r <= twm_pkg::CTRL_RST[twm_pkg::CTRL_EN];
      ie_r <= twm_pkg::CTRL_RST[twm_pkg::CTRL_IE];
    end else if (ctrl_wr) begin
      ackena_r <= ctrl_wdata[twm_pkg::CTRL_ACKEN];
      sta_r <= ctrl_wdata[twm_pkg::CTRL_START];
      en_r <= ctrl_wdata[twm_pkg::CTRL_EN]; // [R9]
      ie_r <= ctrl_wdata[twm_pkg::CTRL_IE];
    end
  end

  // Stop request, cleared by hardware once the stop is on the bus
  always_ff @(posedge clock) begin
    if (rst) begin
      sto_r <= twm_pkg::CTRL_RST[twm_pkg::CTRL_STOP];
    end else if (seq_r == twm_pkg::SEQ_STOP && tick && qtr_r == 2'd2) begin
      sto_r <= 1'b0; // [R21]
    end else if (ctrl_wr) begin
      sto_r <= ctrl_wdata[twm_pkg::CTRL_STOP];
    end
  end

  // Data register and write collision
  always_ff @(posedge clock) begin
    if (rst) begin
      data_r <= twm_pkg::DATA_RST;
      wc_r <= twm_pkg::CTRL_RST[twm_pkg::CTRL_WCOL];
    end else begin
      // Received byte takes the last sampled bit too
      if (end_bit && rx_r && bit_r == 4'd7) begin
        data_r <= {shift_r[6:0], sda_s};
      end else if (data_wr && flag_r) begin
        data_r <= data_wdata; // [R12] [R15]
      end
      // Collision judged on every write, whatever else happens
      if (data_wr) begin
        wc_r <= !flag_r; // [R14]
      end
    end
  end

  // Bus busy tracking from start and stop conditions
  always_ff @(posedge clock) begin
    if (rst) begin
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      sda_d_r <= sda_s;
      if (scl_s && sda_d_r && !sda_s) begin
        busy_r <= 1'b1;
      end else if (scl_s && !sda_d_r && sda_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Quarter counter
  always_ff @(posedge clock) begin
    if (rst || seq_r == twm_pkg::SEQ_IDLE || seq_r == twm_pkg::SEQ_HOLD) begin
      cnt_r <= 16'h0000;
      qtr_r <= 2'd0;
    end else if (tick) begin
      cnt_r <= 16'h0000;
      qtr_r <= qtr_r + 2'd1;
    end else if (!(qtr_r[1] && !scl_s)) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // Sequencer and line drive
  always_ff @(posedge clock) begin
    if (rst || !en_r) begin
      seq_r <= twm_pkg::SEQ_IDLE; // [R9]
      role_r <= twm_pkg::ROLE_NONE;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      bit_r <= 4'd0;
      shift_r <= 8'h00;
      addr_phase_r <= 1'b0;
      rx_r <= 1'b0;
      ack_bit_r <= 1'b0;
      repeat_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      case (seq_r)
        twm_pkg::SEQ_IDLE: begin
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
          repeat_r <= 1'b0;
          lost_r <= 1'b0;
          if (sta_r && !flag_r && !busy_r) begin
            seq_r <= twm_pkg::SEQ_START; // [R10]
          end
        end
        twm_pkg::SEQ_START: begin
          sda_oe_r <= 1'b1;
          if (tick && qtr_r == 2'd1) begin
            scl_oe_r <= 1'b1;
            addr_phase_r <= 1'b1;
            seq_r <= twm_pkg::SEQ_HOLD; // [R11]
          end
        end
        twm_pkg::SEQ_HOLD: begin
          scl_oe_r <= 1'b1; // [R19]
          if (!flag_r) begin // [R4]
            if (sto_r) begin
              sda_oe_r <= 1'b1;
              seq_r <= twm_pkg::SEQ_STOP;
            end else if (sta_r) begin
              sda_oe_r <= 1'b0;
              seq_r <= twm_pkg::SEQ_RSTART; // [R18]
            end else begin
              bit_r <= 4'd0;
              ack_bit_r <= 1'b0;
              rx_r <= !addr_phase_r && role_r == twm_pkg::ROLE_MASTER_RX;
              shift_r <= data_r;
              seq_r <= twm_pkg::SEQ_BIT; // [R15]
            end
          end
        end
        twm_pkg::SEQ_BIT: begin
          // Data moves one quarter after the clock falls, never with it
          if (qtr_r == 2'd0) begin
            scl_oe_r <= 1'b1;
          end else if (qtr_r == 2'd1) begin
            if (ack_bit_r) begin
              sda_oe_r <= rx_r && ackena_r; // [R3]
            end else begin
              sda_oe_r <= !rx_r && !shift_r[7]; // [R2]
            end
          end else if (qtr_r[1]) begin
            scl_oe_r <= 1'b0;
          end
          if (end_bit) begin
            if (!ack_bit_r && !rx_r && shift_r[7] && !sda_s) begin
              lost_r <= 1'b1;
            end
            if (!ack_bit_r) begin
              shift_r <= {shift_r[6:0], sda_s};
            end
            bit_r <= bit_r + 4'd1;
            ack_bit_r <= (bit_r == 4'd7);
            if (!ack_bit_r && !rx_r && shift_r[7] && !sda_s) begin
              scl_oe_r <= 1'b0;
              sda_oe_r <= 1'b0;
              role_r <= twm_pkg::ROLE_NONE;
              seq_r <= twm_pkg::SEQ_IDLE; // [R13]
            end else if (bit_r == 4'(twm_pkg::BITS_PER_BYTE - 1)) begin
              scl_oe_r <= 1'b1;
              if (addr_phase_r) begin
                role_r <= data_r[0] ? twm_pkg::ROLE_MASTER_RX : twm_pkg::ROLE_MASTER_TX; // [R6]
              end
              addr_phase_r <= 1'b0;
              seq_r <= twm_pkg::SEQ_HOLD;
            end
          end
        end
        twm_pkg::SEQ_RSTART: begin
          sda_oe_r <= 1'b0;
          if (tick && qtr_r == 2'd0) begin
            scl_oe_r <= 1'b0;
          end
          if (tick && qtr_r == 2'd2) begin
            repeat_r <= 1'b1;
            seq_r <= twm_pkg::SEQ_START; // [R17]
          end
        end
        twm_pkg::SEQ_STOP: begin
          if (tick && qtr_r == 2'd0) begin
            scl_oe_r <= 1'b0;
          end
          if (tick && qtr_r == 2'd2) begin
            sda_oe_r <= 1'b0;
            role_r <= twm_pkg::ROLE_NONE;
            seq_r <= twm_pkg::SEQ_IDLE; // [R20]
          end
        end
        default: begin
          seq_r <= twm_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Checks on the sequencer and registers
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  suspend_flag_a: assert property (flag_r && seq_r == twm_pkg::SEQ_HOLD |=> seq_r == twm_pkg::SEQ_HOLD) // [R4]
    else $error("transfer moved while flag set");
  hold_scl_a: assert property (flag_r && $past(flag_r) && seq_r == twm_pkg::SEQ_HOLD |-> scl_oe) // [R19]
    else $error("clock released while flag set");
  flag_clear_a: assert property (ctrl_wr && ctrl_wdata[7] && !set_flag |=> !flag_r) // [R8]
    else $error("flag not cleared by writing one");
  wcol_set_a: assert property (data_wr && !flag_r |=> wc_r && serial_data_reg == $past(serial_data_reg)) // [R14]
    else $error("write collision not flagged");
  status_same_a: assert property (set_flag |=> flag_r && serial_status_reg == ($past(code_nxt) & twm_pkg::ST_MASK)) // [R22]
    else $error("status not updated with flag");
  start_code_a: assert property (seq_r == twm_pkg::SEQ_START ##1 seq_r == twm_pkg::SEQ_HOLD |-> flag_r &&
      (serial_status_reg == 8'h08 || serial_status_reg == 8'h10)) // [R11]
    else $error("wrong start status");
  stop_done_a: assert property (seq_r == twm_pkg::SEQ_STOP ##1 seq_r == twm_pkg::SEQ_IDLE |-> !$rose(flag_r) && !sto_r) // [R20]
    else $error("stop raised flag or kept request");
  enable_off_a: assert property (!en_r |=> seq_r == twm_pkg::SEQ_IDLE && !scl_oe && !sda_oe) // [R9]
    else $error("active while disabled");
  free_start_a: assert property (seq_r == twm_pkg::SEQ_IDLE && busy_r |=> seq_r != twm_pkg::SEQ_START) // [R10]
    else $error("start on busy bus");
  addr_code_a: assert property (set_flag && addr_phase_r && !data_r[0] && !lost_r |=>
      role_r == twm_pkg::ROLE_MASTER_TX && (serial_status_reg == 8'h18 || serial_status_reg == 8'h20)) // [R13]
    else $error("wrong write address status");
  data_code_a: assert property (set_flag && !addr_phase_r && !rx_r && !lost_r && seq_r == twm_pkg::SEQ_BIT |=>
      serial_status_reg == 8'h28 || serial_status_reg == 8'h30) // [R23]
    else $error("wrong data status");
endmodule // twm_master
`default_nettype wire

// ### verif/twm_slave_model.sv
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // Bus lines as seen on the wire
  input wire logic scl,
  input wire logic sda,
  // Behaviour controls
  input wire logic nack_data,
  input wire logic stretch,
  // Open-drain pulls, high pulls the line low
  output logic sda_pull,
  output logic scl_pull
);
  logic [7:0] shift;
  logic sel;
  logic first;
  int bitn;
  logic [7:0] got[$];
  // Lines start released
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    bitn = 0;
    sel = 1'b0;
    first = 1'b0;
  end
  // Start or repeated start opens a new address phase
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      first = 1'b1;
    end
  end
  // Stop deselects and frees the data line
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      first = 1'b0;
      sel = 1'b0;
      sda_pull = 1'b0;
    end
  end
  // Bits taken msb first while the clock line is high
  always @(posedge scl) begin
    if (bitn < 8) shift = {shift[6:0], sda};
    bitn++;
  end
  // Acknowledge slot after the eighth bit, freed after the ninth
  always @(negedge scl) begin
    if (bitn == 8) begin
      if (first) sel = (shift[7:1] == ADDR);
      else if (sel && !nack_data) got.push_back(shift);
      sda_pull = sel && (first || !nack_data);
      first = 1'b0;
    end else if (bitn == 9) begin
      sda_pull = 1'b0;
      bitn = 0;
    end
    // Slow answer: hold the clock line low a while
    if (stretch) begin
      scl_pull = 1'b1;
      #200;
      scl_pull = 1'b0;
    end
  end
endmodule // twm_slave_model
`default_nettype wire

// ### verif/test_twm_master.sv
// Self-checking testbench for the two-wire master transmitter
`timescale 1ns/100ps
`default_nettype none
module test_twm_master;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [7:0] RX_ACK = 8'h40;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ctrl_wr = 1'b0;
  logic data_wr = 1'b0;
  logic nack_data = 1'b0;
  logic stretch = 1'b0;
  logic ext_pull = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] ctrl_q, data_q, status_q;
  logic [2:0] role;
  logic scl_out, scl_oe, sda_out, sda_oe, s_sda_pull, s_scl_pull;
  logic [7:0] bytes_q[2] = '{8'h3C, 8'hA5};
  int failures = 0;
  int checks_done = 0;
  wire logic scl_w;
  wire logic sda_w;
  // Pulled-up wires, low while any party pulls
  assign scl_w = !(scl_oe || s_scl_pull);
  assign sda_w = !(sda_oe || s_sda_pull || ext_pull);
  // System clock
  always #4 clock = ~clock;
  twm_master #(.QTR(4), .RX_ADDR_ACK(RX_ACK)) DUT (.clock(clock), .rst(rst), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .serial_control_reg(ctrl_q), .data_wr(data_wr), .data_wdata(data_wdata),
    .serial_data_reg(data_q), .serial_status_reg(status_q), .role(role), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  twm_slave_model #(.ADDR(ADDR)) u_slave (.scl(scl_w), .sda(sda_w), .nack_data(nack_data),
    .stretch(stretch), .sda_pull(s_sda_pull), .scl_pull(s_scl_pull));
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic ctrl(input logic [7:0] v);
    @(posedge clock);
    ctrl_wr <= 1'b1;
    ctrl_wdata <= v;
    @(posedge clock);
    ctrl_wr <= 1'b0;
    #1;
  endtask
  task automatic dwr(input logic [7:0] v);
    @(posedge clock);
    data_wr <= 1'b1;
    data_wdata <= v;
    @(posedge clock);
    data_wr <= 1'b0;
    #1;
  endtask
  // Bounded wait for a control bit to reach a level
  task automatic wait_bit(input int idx, input logic val);
    int n;
    n = 0;
    while (ctrl_q[idx] !== val) begin
      idle(1);
      n++;
      if (n > 3000) begin
        failures++;
        $display("[ERR] t=%0t timeout ctrl=%h status=%h", $time, ctrl_q, status_q);
        wrap_up();
      end
    end
  endtask
  task automatic send(input logic [7:0] v);
    dwr(v);
    ctrl(8'h84);
    wait_bit(7, 1'b1);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    idle(1);
    check(ctrl_q, twm_pkg::CTRL_RST);
    check(status_q, twm_pkg::STATUS_RST);
    check(data_q, twm_pkg::DATA_RST);
    check({3'b000, role, scl_oe, sda_oe}, 8'h00);
    check({6'b000000, scl_out, sda_out}, 8'h00); // Open drain, never driven high
    $display("test reset done");
    ctrl(8'hA0);
    idle(100);
    check({ctrl_q[7], 6'b000000, sda_oe}, 8'h00);
    dwr(8'h55);
    check({7'b0000000, ctrl_q[3]}, 8'h01);
    check(data_q, 8'hFF);
    $display("test disabled and collision done");
    ext_pull <= 1'b1;
    idle(10);
    ctrl(8'hA4);
    idle(100);
    check({7'b0000000, ctrl_q[7]}, 8'h00);
    ext_pull <= 1'b0;
    wait_bit(7, 1'b1);
    check(status_q, twm_pkg::ST_START_SENT);
    idle(60);
    check({ctrl_q[7], 5'b00000, scl_oe, sda_oe}, 8'h83);
    $display("test start done");
    dwr({ADDR, 1'b0});
    check({7'b0000000, ctrl_q[3]}, 8'h00);
    ctrl(8'h84);
    check({7'b0000000, ctrl_q[7]}, 8'h00);
    wait_bit(7, 1'b1);
    check(status_q, twm_pkg::ST_ADDR_ACK);
    check({5'b00000, role}, 8'h01);
    stretch <= 1'b1;
    foreach (bytes_q[i]) begin
      send(bytes_q[i]);
      check(status_q & twm_pkg::ST_MASK, twm_pkg::ST_DATA_ACK);
    end
    nack_data <= 1'b1;
    send(8'h5A);
    check(status_q, twm_pkg::ST_DATA_NACK);
    nack_data <= 1'b0;
    stretch <= 1'b0;
    $display("test write bytes done");
    ctrl(8'hA4);
    wait_bit(7, 1'b1);
    check(status_q, twm_pkg::ST_RSTART_SENT);
    send({7'h11, 1'b0});
    check(status_q, twm_pkg::ST_ADDR_NACK);
    ctrl(8'hA4);
    wait_bit(7, 1'b1);
    check(status_q, twm_pkg::ST_RSTART_SENT);
    send({ADDR, 1'b1});
    check(status_q, RX_ACK);
    check({5'b00000, role}, 8'h02);
    $display("test repeated start done");
    ctrl(8'h94);
    wait_bit(4, 1'b0);
    idle(60);
    check({7'b0000000, ctrl_q[7]}, 8'h00);
    check({6'b000000, scl_w, sda_w}, 8'h03);
    check(8'(u_slave.got.size()), 8'h02);
    foreach (bytes_q[i]) check(u_slave.got[i], bytes_q[i]);
    $display("test stop done");
    wrap_up();
  end
endmodule // test_twm_master
`default_nettype wire
